// ===== sph_consts.vh
/*
 * Constants for the strobed parallel handshake port: register offsets,
 * control bit positions, reset values and strobe timing.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef SPH_CONSTS_VH
`define SPH_CONSTS_VH

// ****************************************
// Register offsets (byte addresses).
// ****************************************
`define SPH_OFS_PORT_A 16'h1000
`define SPH_OFS_CTRL 16'h1002
`define SPH_OFS_PORT_C 16'h1003
`define SPH_OFS_PORT_B 16'h1004
`define SPH_OFS_PORT_CL 16'h1005
`define SPH_OFS_DDR_C 16'h1007

// ****************************************
// Control register bit positions.
// ****************************************
`define SPH_BIT_FLAG 7
`define SPH_BIT_IRQ_EN 6
`define SPH_BIT_OPEN_DRAIN 5
`define SPH_BIT_HANDSHAKE 4
`define SPH_BIT_HS_DIR 3
`define SPH_BIT_PULSE 2
`define SPH_BIT_EDGE 1
`define SPH_BIT_POLARITY 0

// ****************************************
// Reset values and timing.
// ****************************************
`define SPH_CTRL_RESET 8'h03
`define SPH_BYTE_RESET 8'h00
`define SPH_STROBE_CYCLES 2

`endif

// ===== sph_sync.v
/*
 * Two-flip-flop synchroniser with edge detection behind the second stage.
 * Assumes the input is asynchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module sph_sync (
	// Clock and reset.
	input wire mclk,
	input wire srst,
	// Asynchronous level in.
	input wire async_in,
	// Synchronised level and edge pulses.
	output wire sync_out,
	output wire rise_out,
	output wire fall_out
);
	reg stage1_ff;
	reg stage2_ff;
	reg stage3_ff;

	// The chain keeps shifting through reset, so a line that is already high
	// when reset ends shows no false edge; reset must last three cycles for this.
	always @(posedge mclk) begin
		stage1_ff <= async_in;
		stage2_ff <= stage1_ff;
		stage3_ff <= stage2_ff;
	end

	assign sync_out = stage2_ff;
	assign rise_out = stage2_ff & ~stage3_ff & ~srst;
	assign fall_out = ~stage2_ff & stage3_ff & ~srst;
endmodule // sph_sync

`default_nettype wire

// ===== sph_pulse.v
/*
 * Fixed-length pulse generator: a trigger starts a pulse of LEN cycles.
 * Assumes trigger comes from logic on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module sph_pulse #(
	parameter LEN = 2
) (
	// Clock and reset.
	input wire mclk,
	input wire srst,
	// One-cycle trigger.
	input wire trigger,
	// Pulse level, active high.
	output wire pulse
);
	reg [3:0] count_ff;

	always @(posedge mclk) begin
		if (srst) begin
			count_ff <= 4'h0;
		end else if (trigger) begin
			count_ff <= LEN[3:0];
		end else if (count_ff != 4'h0) begin
			count_ff <= count_ff - 4'h1;
		end
	end

	assign pulse = (count_ff != 4'h0);
endmodule // sph_pulse

`default_nettype wire

// ===== sph_port.v
/*
 * Strobed parallel handshake port: port B strobed output, port C with
 * strobed input latch, full input and output handshakes, open-drain option.
 * Assumes a simple register port on mclk and asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sph_consts.vh"

// What this block does
// - Each port B write in simple mode emits a two-cycle output strobe.
// - Polarity bit: 0 makes output strobe active low, 1 active high.
// - Simple mode latches port C pins on each input strobe assertion.
// - Edge select bit: 0 falling edge, 1 rising edge of input strobe.
// - Selected active edge on input strobe sets the status flag.
// - Flag clears after control read with flag set, then latch read, or latch write in output handshake.
// - Interrupt enable bit gates the flag onto the interrupt request.
// - In simple input mode port C lines stay ordinary GPIO by direction.
// - Direction select: 0 input handshake, 1 output handshake, only in handshake.
// - Pulse select: 0 interlocked strobe level, 1 two-cycle strobe pulse.
// - Input handshake: ready strobe asserted, drops after input strobe latches data.
// - Input handshake: ready strobe reasserts after software reads the latch.
// - Input handshake lines are latched, static input or static output.
// - Output handshake: writing the latch register asserts the output strobe.
// - Three-state variant drives latched data on input lines while strobe active.
// - Output handshake drives all pins while strobe active, else follows direction.
// - Open-drain bit makes all eight port C outputs open drain.
// - Strobe and handshake work only in single-chip mode.
// - Writing the latch register also updates the driven port C value.
// - Direction bits: 0 input, 1 output, all reset to 0.
module sph_port #(
	// Output strobe pulse length in clock cycles.
	parameter STROBE_LEN = `SPH_STROBE_CYCLES
) (
	// Clock and reset.
	input wire mclk,
	input wire srst,
	// Register port.
	input wire [15:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Mode strap: high in single-chip mode.
	input wire single_chip,
	// Port A pins read back.
	input wire [7:0] port_a_in,
	// Port B outputs.
	output wire [7:0] port_b_out,
	// Port C pins.
	input wire [7:0] port_c_in,
	output wire [7:0] port_c_out,
	output wire [7:0] port_c_oe_n,
	// Strobe lines.
	input wire strobe_in_line,
	output wire strobe_out_line,
	// Interrupt request, active high.
	output wire strobe_irq
);
	// ****************************************
	// Registers.
	// ****************************************
	reg strobe_status_flag_ff;
	reg strobe_irq_enable_ff;
	reg port_c_open_drain_ff;
	reg full_handshake_select_ff;
	reg handshake_direction_ff;
	reg pulse_style_select_ff;
	reg strobe_edge_select_ff;
	reg strobe_out_polarity_ff;
	reg [7:0] port_b_output_data_ff;
	reg [7:0] port_c_data_ff;
	reg [7:0] port_c_latched_data_ff;
	reg [7:0] port_c_direction_ff;
	reg clear_armed_ff;
	reg ready_level_ff;
	reg nxt_flag;

	wire [7:0] pc_sync;
	wire [7:0] pa_sync;
	wire strobe_in_line_level;
	wire strobe_in_line_rise;
	wire strobe_in_line_fall;
	wire pulse_b;
	wire pulse_hs;

	// Control reset value; the flag is bit 7, the writable bits below it.
	localparam [7:0] CTRL_RESET = `SPH_CTRL_RESET;

	// Every pin passes two flip-flops, so strobe actions trail the pin by three cycles.
	// ****************************************
	// Pin synchronisers.
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			sph_sync u_pc (
				.mclk(mclk),
				.srst(srst),
				.async_in(port_c_in[gi]),
				.sync_out(pc_sync[gi]),
				.rise_out(),
				.fall_out()
			);
			sph_sync u_pa (
				.mclk(mclk),
				.srst(srst),
				.async_in(port_a_in[gi]),
				.sync_out(pa_sync[gi]),
				.rise_out(),
				.fall_out()
			);
		end
	endgenerate

	sph_sync u_strobe_in_line (
		.mclk(mclk),
		.srst(srst),
		.async_in(strobe_in_line),
		.sync_out(strobe_in_line_level),
		.rise_out(strobe_in_line_rise),
		.fall_out(strobe_in_line_fall)
	);

	// ****************************************
	// Decode.
	// ****************************************
	wire wr_ctrl = reg_wr && (reg_addr == `SPH_OFS_CTRL);
	wire wr_pc = reg_wr && (reg_addr == `SPH_OFS_PORT_C);
	wire wr_pb = reg_wr && (reg_addr == `SPH_OFS_PORT_B);
	wire wr_pcl = reg_wr && (reg_addr == `SPH_OFS_PORT_CL);
	wire wr_ddr = reg_wr && (reg_addr == `SPH_OFS_DDR_C);
	wire rd_ctrl = reg_rd && (reg_addr == `SPH_OFS_CTRL);
	wire rd_pcl = reg_rd && (reg_addr == `SPH_OFS_PORT_CL);

	wire hs_on = full_handshake_select_ff & single_chip;
	wire hs_out = hs_on & handshake_direction_ff;
	wire hs_in = hs_on & ~handshake_direction_ff;
	wire active_edge = single_chip & (strobe_edge_select_ff ? strobe_in_line_rise : strobe_in_line_fall);
	wire strobe_in_line_active = strobe_edge_select_ff ? strobe_in_line_level : ~strobe_in_line_level;

	// ****************************************
	// Control and data registers.
	// ****************************************
	always @* begin
		nxt_flag = strobe_status_flag_ff;
		// Clear completes on latch access after an armed control read.
		if (clear_armed_ff && ((hs_out && wr_pcl) || (!hs_out && rd_pcl))) begin
			nxt_flag = 1'b0;
		end
		// A new edge wins over the clear.
		if (active_edge) begin
			nxt_flag = 1'b1;
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			strobe_status_flag_ff <= CTRL_RESET[`SPH_BIT_FLAG];
			{strobe_irq_enable_ff, port_c_open_drain_ff, full_handshake_select_ff, handshake_direction_ff,
				pulse_style_select_ff, strobe_edge_select_ff, strobe_out_polarity_ff} <= CTRL_RESET[6:0];
			port_b_output_data_ff <= `SPH_BYTE_RESET;
			port_c_data_ff <= `SPH_BYTE_RESET;
			port_c_latched_data_ff <= `SPH_BYTE_RESET;
			port_c_direction_ff <= `SPH_BYTE_RESET;
			clear_armed_ff <= 1'b0;
		end else begin
			strobe_status_flag_ff <= nxt_flag;
			if (rd_ctrl) begin
				clear_armed_ff <= strobe_status_flag_ff;
			end else if (!nxt_flag) begin
				clear_armed_ff <= 1'b0;
			end
			if (wr_ctrl) begin
				strobe_irq_enable_ff <= reg_wdata[`SPH_BIT_IRQ_EN];
				port_c_open_drain_ff <= reg_wdata[`SPH_BIT_OPEN_DRAIN];
				full_handshake_select_ff <= reg_wdata[`SPH_BIT_HANDSHAKE];
				handshake_direction_ff <= reg_wdata[`SPH_BIT_HS_DIR];
				pulse_style_select_ff <= reg_wdata[`SPH_BIT_PULSE];
				strobe_edge_select_ff <= reg_wdata[`SPH_BIT_EDGE];
				strobe_out_polarity_ff <= reg_wdata[`SPH_BIT_POLARITY];
			end
			if (wr_pb) begin
				port_b_output_data_ff <= reg_wdata;
			end
			if (wr_ddr) begin
				port_c_direction_ff <= reg_wdata;
			end
			// Latch register write also drives port C outputs.
			if (wr_pc || wr_pcl) begin
				port_c_data_ff <= reg_wdata;
			end
			if (wr_pcl) begin
				port_c_latched_data_ff <= reg_wdata;
			end else if (active_edge && !hs_out) begin
				port_c_latched_data_ff <= pc_sync;
			end
		end
	end

	// ****************************************
	// Output strobe.
	// ****************************************
	// Interlocked level: set when ready, cleared by the handshake.
	always @(posedge mclk) begin
		if (srst) begin
			ready_level_ff <= 1'b0;
		end else if (wr_ctrl) begin
			// Entering input handshake must raise ready at once; the mode bits only
			// change at this edge, so the decision is taken from the written value.
			// A control write drops a pending output strobe, as no data is offered yet.
			ready_level_ff <= single_chip & reg_wdata[`SPH_BIT_HANDSHAKE] & ~reg_wdata[`SPH_BIT_HS_DIR];
		end else if (!hs_on) begin
			ready_level_ff <= 1'b0;
		end else if (hs_in) begin
			if (active_edge) begin
				ready_level_ff <= 1'b0;
			end else if (rd_pcl) begin
				ready_level_ff <= 1'b1;
			end
		end else begin
			if (wr_pcl) begin
				ready_level_ff <= 1'b1;
			end else if (active_edge) begin
				ready_level_ff <= 1'b0;
			end
		end
	end

	// Port B strobes only in simple mode; in handshake modes port B is a plain output.
	wire pb_trigger = wr_pb && !hs_on && single_chip;

	// Pulsed handshake fires on a latch read in input handshake or a latch write in output handshake.
	wire hs_trigger = hs_on && pulse_style_select_ff && ((hs_in && rd_pcl) || (hs_out && wr_pcl));

	sph_pulse #(.LEN(STROBE_LEN)) u_pulse_b (
		.mclk(mclk),
		.srst(srst),
		.trigger(pb_trigger),
		.pulse(pulse_b)
	);

	sph_pulse #(.LEN(STROBE_LEN)) u_pulse_hs (
		.mclk(mclk),
		.srst(srst),
		.trigger(hs_trigger),
		.pulse(pulse_hs)
	);

	// A pulse still running when single-chip mode ends is cut off at once.
	wire strobe_active = single_chip & (hs_on ? (pulse_style_select_ff ? pulse_hs : ready_level_ff) : pulse_b);
	assign strobe_out_line = strobe_out_polarity_ff ? strobe_active : ~strobe_active;
	assign strobe_irq = strobe_status_flag_ff & strobe_irq_enable_ff;

	// ****************************************
	// Port C pin drive.
	// ****************************************
	// In output handshake, an active input strobe turns every line into an output.
	wire [7:0] drive = (hs_out && strobe_in_line_active) ? 8'hFF : port_c_direction_ff;
	wire [7:0] drive_val = (hs_out && strobe_in_line_active) ? port_c_latched_data_ff : port_c_data_ff;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
			// Open drain only pulls low; a high bit releases the pin.
			assign port_c_oe_n[gi] = ~(drive[gi] & ~(port_c_open_drain_ff & drive_val[gi]));
			assign port_c_out[gi] = drive_val[gi];
		end
	endgenerate

	assign port_b_out = port_b_output_data_ff;

	// ****************************************
	// Read data, one cycle after the strobe.
	// ****************************************
	// Read data is captured at the strobe so a later write cannot alter it.
	always @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					`SPH_OFS_PORT_A: reg_rdata <= pa_sync;
					`SPH_OFS_CTRL: reg_rdata <= {strobe_status_flag_ff, strobe_irq_enable_ff, port_c_open_drain_ff,
						full_handshake_select_ff, handshake_direction_ff, pulse_style_select_ff,
						strobe_edge_select_ff, strobe_out_polarity_ff};
					`SPH_OFS_PORT_C: reg_rdata <= (port_c_direction_ff & port_c_data_ff) |
						(~port_c_direction_ff & pc_sync);
					`SPH_OFS_PORT_B: reg_rdata <= port_b_output_data_ff;
					`SPH_OFS_PORT_CL: reg_rdata <= port_c_latched_data_ff;
					`SPH_OFS_DDR_C: reg_rdata <= port_c_direction_ff;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule // sph_port

`default_nettype wire

// ===== sph_port_properties.sv
/*
 * Concurrent checks on the ports of the strobed parallel handshake port.
 * Assumes one clock, mclk, with synchronous reset srst; bound from tb.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sph_consts.vh"

module sph_port_properties (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Register port.
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pins.
	input wire logic single_chip,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_c_in,
	input wire logic [7:0] port_c_out,
	input wire logic [7:0] port_c_oe_n,
	input wire logic strobe_in_line,
	input wire logic strobe_out_line,
	input wire logic strobe_irq
);
	// ********
	// Shadows.
	// ********
	// Mode bits are tracked here so that each check sees the mode of its own cycle.
	logic [6:0] ctrl_ff;
	logic [7:0] ddr_ff;
	wire logic ien = ctrl_ff[6], od = ctrl_ff[5], hs = ctrl_ff[4], pulse_style_select = ctrl_ff[2], edg = ctrl_ff[1];
	wire logic pol = ctrl_ff[0], ohs = single_chip & ctrl_ff[4] & ctrl_ff[3];
	always @(posedge mclk) begin
		if (srst) begin
			ctrl_ff <= 7'h03;
			ddr_ff <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == `SPH_OFS_CTRL) ctrl_ff <= reg_wdata[6:0];
			if (reg_addr == `SPH_OFS_DDR_C) ddr_ff <= reg_wdata;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_sel_edge;
		$changed(strobe_in_line) && strobe_in_line == edg;
	endsequence
	sequence s_ack_held;
		(ohs && !od && strobe_in_line == edg)[*4];
	endsequence
	sequence s_strobe_on2;
		(strobe_out_line == pol)[*2];
	endsequence
	// ***********
	// Properties.
	// ***********
	a_ctrl_readback: assert property (reg_rd && reg_addr == `SPH_OFS_CTRL
		|=> reg_rdata[6:0] == $past(ctrl_ff)) else $error("control read back differs");
	a_dir_follow: assert property (single_chip && !od && !(hs && ctrl_ff[3])
		|-> port_c_oe_n == ~ddr_ff) else $error("port C enables differ from direction");
	a_open_drain: assert property (single_chip && od
		|-> (~port_c_oe_n & port_c_out) == 8'h00) else $error("open drain pin drives high");
	a_port_b_output_data_pulse: assert property (single_chip && !hs && reg_wr && reg_addr == `SPH_OFS_PORT_B
		|=> s_strobe_on2) else $error("port B strobe pulse missing");
	a_irq_gate: assert property (!ien |-> !strobe_irq)
		else $error("interrupt while disabled");
	a_flag_set: assert property ((single_chip && ien) ##0 s_sel_edge
		|-> ##[1:4] strobe_irq) else $error("selected edge did not set flag");
	a_hs_ready: assert property (ohs && reg_wr && reg_addr == `SPH_OFS_PORT_CL
		|=> strobe_out_line == pol) else $error("latch write did not raise strobe");
	a_hs_drive: assert property (s_ack_held |-> port_c_oe_n == 8'h00)
		else $error("port C not driven during acknowledge");
	a_hs_drop: assert property ((ohs && !pulse_style_select) ##0 s_sel_edge
		|-> ##[1:4] strobe_out_line != pol) else $error("strobe held after acknowledge");
	a_idle_off: assert property (!single_chip |-> strobe_out_line != pol)
		else $error("strobe active outside single chip mode");
endmodule // sph_port_properties

`default_nettype wire

// ===== sph_peer.sv
/*
 * Model of the outside parallel system: drives port C inputs and the input strobe.
 * Assumes the bench commands each acknowledge with go and a hold length.
 */
`timescale 1ns/1ps
`default_nettype none

module sph_peer (
	// Clock.
	input wire logic mclk,
	// Device side of port C.
	input wire logic [7:0] port_c_out,
	input wire logic [7:0] port_c_oe_n,
	// Bench commands.
	input wire logic go,
	input wire logic idle,
	input wire logic [3:0] hold,
	input wire logic [7:0] ext_data,
	// Toward the device, and data taken in.
	output wire logic [7:0] port_c_in,
	output wire logic strobe_in_line,
	output logic [7:0] got_ff
);
	// ***********
	// Behaviour.
	// ***********
	logic [3:0] cnt_ff = 4'h0;
	assign port_c_in = (port_c_oe_n & ext_data) | (~port_c_oe_n & port_c_out);
	assign strobe_in_line = (cnt_ff != 4'h0) ? ~idle : idle;
	always @(posedge mclk) begin
		if (go) begin
			cnt_ff <= hold;
		end else if (cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
		// Pins are read on the last active cycle, when the device is surely driving.
		if (cnt_ff == 4'h1) begin
			got_ff <= port_c_in;
		end
	end
endmodule // sph_peer

`default_nettype wire

// ===== tb.sv
/*
 * Self-checking bench for the strobed parallel handshake port.
 * Assumes the design, its constants header, the checker and the peer model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sph_consts.vh"

bind sph_port sph_port_properties u_props (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.single_chip, .port_a_in, .port_b_out, .port_c_in, .port_c_out, .port_c_oe_n, .strobe_in_line,
	.strobe_out_line, .strobe_irq);

module tb;
	logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, single_chip = 1'b1, go = 1'b0, idle = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00, port_a_in = 8'h00, ext = 8'h00, rd_v, d, m;
	logic [3:0] hold = 4'h6;
	logic [31:0] rng = 32'hF99BBCF6;
	int error_cnt = 0, n_tests = 0;
	wire logic [7:0] reg_rdata, port_b_out, port_c_in, port_c_out, port_c_oe_n, got_ff;
	wire logic strobe_in_line, strobe_out_line, strobe_irq;
	sph_port u_dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .single_chip, .port_a_in,
		.port_b_out, .port_c_in, .port_c_out, .port_c_oe_n, .strobe_in_line, .strobe_out_line, .strobe_irq);
	sph_peer u_peer (.mclk, .port_c_out, .port_c_oe_n, .go, .idle, .hold, .ext_data(ext), .port_c_in,
		.strobe_in_line, .got_ff);
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// ********
	// Helpers.
	// ********
	function automatic logic [7:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	function automatic logic [7:0] mix(input logic [7:0] o, input logic [7:0] dr, input logic [7:0] x);
		return (o & dr) | (x & ~dr);
	endfunction
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [15:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rd_v = reg_rdata;
	endtask
	task ack(input logic [3:0] h);
		@(posedge mclk);
		hold <= h;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
	endtask
	task wait_irq();
		int k;
		for (k = 0; k < 20 && strobe_irq !== 1'b1; k++) cyc(1);
		if (strobe_irq !== 1'b1) begin
			chk(8'(strobe_irq), 8'h01);
			print_verdict();
		end
	endtask
	// *********
	// Sequence.
	// *********
	initial begin
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		port_a_in <= xs();
		#1;
		chk(port_c_oe_n, 8'hFF);
		rd(`SPH_OFS_CTRL);
		chk(rd_v, `SPH_CTRL_RESET);
		rd(`SPH_OFS_DDR_C);
		chk(rd_v, `SPH_BYTE_RESET);
		wr(16'h1001, xs());
		rd(16'h1001);
		chk(rd_v, 8'h00);
		for (int i = 0; i < 4; i++) begin
			m = xs();
			wr(`SPH_OFS_CTRL, {7'h01, i[0]});
			wr(`SPH_OFS_PORT_B, m);
			chk(8'(strobe_out_line), 8'(i[0]));
			chk(port_b_out, m);
			cyc(3);
			chk(8'(strobe_out_line), 8'(!i[0]));
		end
		@(posedge mclk);
		single_chip <= 1'b0;
		wr(`SPH_OFS_PORT_B, xs());
		chk(8'(strobe_out_line), 8'h00);
		@(posedge mclk);
		single_chip <= 1'b1;
		m = xs();
		d = xs();
		ext <= xs();
		wr(`SPH_OFS_DDR_C, m);
		wr(`SPH_OFS_PORT_C, d);
		chk(port_c_oe_n, ~m);
		rd(`SPH_OFS_PORT_C);
		chk(rd_v, mix(d, m, ext));
		wr(`SPH_OFS_PORT_CL, ~d);
		chk(port_c_out & m, ~d & m);
		wr(`SPH_OFS_CTRL, 8'h23);
		wr(`SPH_OFS_DDR_C, 8'hFF);
		chk(port_c_oe_n, ~d);
		wr(`SPH_OFS_DDR_C, 8'h00);
		for (int e = 0; e < 2; e++) begin
			@(posedge mclk);
			idle <= !e[0];
			ext <= xs();
			cyc(6);
			wr(`SPH_OFS_CTRL, {6'h10, e[0], 1'b1});
			rd(`SPH_OFS_CTRL);
			rd(`SPH_OFS_PORT_CL);
			chk(8'(strobe_irq), 8'h00);
			ack(4'h6);
			wait_irq();
			rd(`SPH_OFS_PORT_CL);
			chk(rd_v, ext);
			chk(8'(strobe_irq), 8'h01);
			rd(`SPH_OFS_CTRL);
			chk(rd_v, {6'h30, e[0], 1'b1});
			rd(`SPH_OFS_PORT_CL);
			chk(8'(strobe_irq), 8'h00);
		end
		wr(`SPH_OFS_CTRL, 8'h13);
		chk(8'(strobe_out_line), 8'h01);
		ext <= xs();
		ack(4'h6);
		cyc(6);
		chk(8'(strobe_out_line), 8'h00);
		rd(`SPH_OFS_PORT_CL);
		chk(rd_v, ext);
		cyc(1);
		chk(8'(strobe_out_line), 8'h01);
		wr(`SPH_OFS_CTRL, 8'h1B);
		d = xs();
		wr(`SPH_OFS_PORT_CL, d);
		chk(8'(strobe_out_line), 8'h01);
		chk(port_c_oe_n, 8'hFF);
		ack(4'h9);
		cyc(12);
		chk(got_ff, d);
		chk(8'(strobe_out_line), 8'h00);
		chk(port_c_oe_n, 8'hFF);
		wr(`SPH_OFS_CTRL, 8'h1F);
		wr(`SPH_OFS_PORT_CL, xs());
		chk(8'(strobe_out_line), 8'h01);
		cyc(3);
		chk(8'(strobe_out_line), 8'h00);
		wr(`SPH_OFS_CTRL, 8'h17);
		ack(4'h6);
		cyc(6);
		rd(`SPH_OFS_PORT_CL);
		chk(8'(strobe_out_line), 8'h01);
		cyc(3);
		chk(8'(strobe_out_line), 8'h00);
		print_verdict();
	end
endmodule // tb

`default_nettype wire
